/* File: rtl/nvmsc_map.vh */
// register map, field positions, reset values and timing counts of the nvm scanner
// assumes word-indexed printed offsets; byte address is four times the index
`ifndef NVMSC_MAP_VH
`define NVMSC_MAP_VH

// ----------------------------------------
// register indices and address width
// ----------------------------------------
`define NVMSC_IDX_END_ADDR 16'h1c92
`define NVMSC_IDX_CUR_ADDR 16'h1c95
`define NVMSC_IDX_CONTROL 16'h1c98
`define NVMSC_IDX_TRIG_SEL 16'h1c99
`define NVMSC_IDX_TAP_MASK 16'h1c9e
`define NVMSC_IDX_IRQ_STAT 16'h1ca8
`define NVMSC_IDX_IRQ_MASK 16'h1ca9
`define NVMSC_IDX_CRC_CTRL 16'h1caa
`define NVMSC_ADDR_W 18

// ----------------------------------------
// control register fields
// ----------------------------------------
`define NVMSC_CTL_EN 7
`define NVMSC_CTL_GO 6
`define NVMSC_CTL_BUSY 5
`define NVMSC_CTL_ABORT 4
`define NVMSC_CTL_IRQM 3
`define NVMSC_CTL_MODE_HI 1
`define NVMSC_CTL_MODE_LO 0

// access modes
`define NVMSC_MODE_CONC 2'h0
`define NVMSC_MODE_BURST 2'h1
`define NVMSC_MODE_PEEK 2'h2
`define NVMSC_MODE_TRIG 2'h3

// crc control fields (our own register)
`define NVMSC_CRC_EN 0
`define NVMSC_CRC_GO 1

// interrupt status fields
`define NVMSC_IRQ_DONE 0
`define NVMSC_IRQ_ABORT 1

// ----------------------------------------
// reset values
// ----------------------------------------
`define NVMSC_RST_END_ADDR 16'hffff
`define NVMSC_RST_CUR_ADDR 16'h0000
`define NVMSC_RST_TAP_MASK 32'h0000_0000
`define NVMSC_RST_TRIG_SEL 4'h0

// ----------------------------------------
// memory and timing
// ----------------------------------------
`define NVMSC_MEM_LAST 16'h7fff
`define NVMSC_FETCH_NS 20
`define NVMSC_CLK_NS 10
`define NVMSC_FETCH_CYC ((`NVMSC_FETCH_NS + `NVMSC_CLK_NS - 1) / `NVMSC_CLK_NS)

`endif

/* File: rtl/nvmsc_scanner.v */
// nvm scanner: walks memory from current to end address, feeds words to the crc engine
// assumes one clock, synchronous inputs, memory answering in a fixed fetch time
//
// Overview of operation
// - 32-bit tap mask, four byte lanes, resets zero, drives crc feedback taps.
// - scanner runs only while enabled; disabling keeps other registers intact.
// - writing go starts scan; hardware clears go at end or crc go low.
// - busy reads one while a fetch cycle is in progress.
// - abort flag shows invalid address or crc disabled; resets to one.
// - irq mode one in non-peek modes pauses scanning during interrupt response.
// - irq mode zero, concurrent or trigger: stall interrupts during each fetch.
// - irq mode zero, burst: stall interrupts until hardware clears go.
// - mode field: 11 trigger, 10 peek, 01 burst, 00 concurrent; peek ignores irq mode.
// - 16-bit current address, loaded by software, increments after every fetch.
// - address register writes ignored while go is set.
// - 16-bit end address resets to all ones.
// - trigger mode: trigger select picks the event input pacing fetches.
// - trigger select decodes eleven sources; 0111 and 1100-1111 reserved.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`include "nvmsc_map.vh"

module nvmsc_scanner
(
   input wire clk,
   input wire rst_b,
   input wire clkEn,
   // register port
   input wire [`NVMSC_ADDR_W-1:0] regAddr,
   input wire [31:0] regWdata,
   input wire [3:0] regBe,
   input wire regWr,
   input wire regRd,
   output reg [31:0] regRdata,
   // interrupt
   output wire irq,
   // cpu interrupt handshake
   input wire cpuIrqActive,
   output wire cpuIrqStall,
   // memory side
   output reg memReq,
   output reg [15:0] memAddr,
   input wire [15:0] memRdata,
   // crc side
   output reg crcDataValid,
   output reg [15:0] crcData,
   output wire [31:0] crcTapMask,
   output wire crcEnable,
   output wire crc_go_bit,
   // trigger sources
   input wire lowFreqInternalOsc,
   input wire refClockOut,
   input wire timer0Overflow,
   input wire timer1Overflow,
   input wire timer2Postscaled,
   input wire timer3Overflow,
   input wire timer4Postscaled,
   input wire logicCell1Out,
   input wire logicCell2Out,
   input wire logicCell3Out,
   input wire logicCell4Out
);

   localparam integer FETCH_INT = `NVMSC_FETCH_CYC;
   localparam [2:0] FETCH_CYC = FETCH_INT[2:0];
   localparam ST_IDLE = 1'b0;
   localparam ST_FETCH = 1'b1;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg [15:0] endAddr_reg;
   reg [15:0] curAddr_reg;
   reg en_reg;
   reg go_reg;
   reg irqMode_reg;
   reg [1:0] mode_reg;
   reg [3:0] trigSel_reg;
   reg [31:0] tapMask_reg;
   reg crc_enable_bit_reg;
   reg crc_go_bit_reg;
   reg [1:0] irqStat_reg;
   reg [1:0] irqMask_reg;
   reg state_reg;
   reg [2:0] waitCnt_reg;
   reg trigPrev_reg;
   reg trigPend_reg;

   wire [15:0] wIdx = regAddr[`NVMSC_ADDR_W-1:2];
   wire wEnd = regWr && (wIdx == `NVMSC_IDX_END_ADDR);
   wire wCur = regWr && (wIdx == `NVMSC_IDX_CUR_ADDR);
   wire wCtl = regWr && (wIdx == `NVMSC_IDX_CONTROL) && regBe[0];
   wire wTrg = regWr && (wIdx == `NVMSC_IDX_TRIG_SEL) && regBe[0];
   wire wTap = regWr && (wIdx == `NVMSC_IDX_TAP_MASK);
   wire wSta = regWr && (wIdx == `NVMSC_IDX_IRQ_STAT) && regBe[0];
   wire wMsk = regWr && (wIdx == `NVMSC_IDX_IRQ_MASK) && regBe[0];
   wire wCrc = regWr && (wIdx == `NVMSC_IDX_CRC_CTRL) && regBe[0];

   // ----------------------------------------
   // trigger selection
   // ----------------------------------------
   reg trigSrc;
   // reserved codes select a constant low, so trigger mode simply never fetches
   always @*
   begin
      case (trigSel_reg)
         4'h0: trigSrc = lowFreqInternalOsc;
         4'h1: trigSrc = refClockOut;
         4'h2: trigSrc = timer0Overflow;
         4'h3: trigSrc = timer1Overflow;
         4'h4: trigSrc = timer2Postscaled;
         4'h5: trigSrc = timer3Overflow;
         4'h6: trigSrc = timer4Postscaled;
         4'h8: trigSrc = logicCell1Out;
         4'h9: trigSrc = logicCell2Out;
         4'ha: trigSrc = logicCell3Out;
         4'hb: trigSrc = logicCell4Out;
         default: trigSrc = 1'b0;
      endcase
   end

   // ----------------------------------------
   // scan control terms
   // ----------------------------------------
   wire isTrig = (mode_reg == `NVMSC_MODE_TRIG);
   wire isBurst = (mode_reg == `NVMSC_MODE_BURST);
   wire isPeek = (mode_reg == `NVMSC_MODE_PEEK);
   wire busy = (state_reg == ST_FETCH);
   wire addrValid = (curAddr_reg <= `NVMSC_MEM_LAST);
   wire abortFlag = !addrValid || !crc_enable_bit_reg;
   wire pastEnd = (curAddr_reg > endAddr_reg);
   // peek only steals idle cycles, so it waits out any interrupt response
   wire irqPause = cpuIrqActive && (isPeek || irqMode_reg);
   wire trigEdge = trigSrc && !trigPrev_reg;
   wire canStart = en_reg && go_reg && crc_go_bit_reg && !abortFlag && !pastEnd
      && !irqPause && (!isTrig || trigPend_reg);
   wire hwClrGo = go_reg && ((pastEnd && !busy) || !crc_go_bit_reg);
   wire fetchDone = busy && (waitCnt_reg == 3'h0);
   wire fetchStart = !busy && canStart && !hwClrGo;

   // interrupt stall toward the cpu, only when irq mode is zero outside peek
   assign cpuIrqStall = en_reg && !irqMode_reg && !isPeek
      && ((isBurst && go_reg) || (!isBurst && busy));

   assign crcTapMask = tapMask_reg;
   assign crcEnable = crc_enable_bit_reg;
   assign crc_go_bit = crc_go_bit_reg;
   assign irq = |(irqStat_reg & irqMask_reg);

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   // software alone moves these; enable never touches the others
   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         tapMask_reg <= `NVMSC_RST_TAP_MASK;
         trigSel_reg <= `NVMSC_RST_TRIG_SEL;
         irqMask_reg <= 2'h0;
         crc_enable_bit_reg <= 1'b0;
         crc_go_bit_reg <= 1'b0;
         en_reg <= 1'b0;
         irqMode_reg <= 1'b0;
         mode_reg <= `NVMSC_MODE_CONC;
      end
      else if (clkEn)
      begin
         // tap mask byte lanes
         if (wTap)
         begin
            if (regBe[0]) tapMask_reg[7:0] <= regWdata[7:0];
            if (regBe[1]) tapMask_reg[15:8] <= regWdata[15:8];
            if (regBe[2]) tapMask_reg[23:16] <= regWdata[23:16];
            if (regBe[3]) tapMask_reg[31:24] <= regWdata[31:24];
         end
         if (wTrg)
            trigSel_reg <= regWdata[3:0];
         if (wMsk)
            irqMask_reg <= regWdata[1:0];
         if (wCrc)
         begin
            crc_enable_bit_reg <= regWdata[`NVMSC_CRC_EN];
            crc_go_bit_reg <= regWdata[`NVMSC_CRC_GO];
         end
         // control fields other than go
         if (wCtl)
         begin
            en_reg <= regWdata[`NVMSC_CTL_EN];
            irqMode_reg <= regWdata[`NVMSC_CTL_IRQM];
            mode_reg <= regWdata[`NVMSC_CTL_MODE_HI:`NVMSC_CTL_MODE_LO];
         end
      end
   end

   // ----------------------------------------
   // scan go bit
   // ----------------------------------------
   // hardware clear comes last so it wins over a software set in one cycle
   always @(posedge clk)
   begin
      if (!rst_b)
         go_reg <= 1'b0;
      else if (clkEn)
      begin
         if (wCtl)
            go_reg <= regWdata[`NVMSC_CTL_GO];
         if (hwClrGo)
            go_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // scan address registers
   // ----------------------------------------
   // writes are dropped while go is set, so a running scan keeps its window;
   // a write after software cleared go lands over a late increment
   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         endAddr_reg <= `NVMSC_RST_END_ADDR;
         curAddr_reg <= `NVMSC_RST_CUR_ADDR;
      end
      else if (clkEn)
      begin
         if (wEnd && !go_reg)
         begin
            if (regBe[0]) endAddr_reg[7:0] <= regWdata[7:0];
            if (regBe[1]) endAddr_reg[15:8] <= regWdata[15:8];
         end
         if (fetchDone)
            curAddr_reg <= curAddr_reg + 16'h0001;
         if (wCur && !go_reg)
         begin
            if (regBe[0]) curAddr_reg[7:0] <= regWdata[7:0];
            if (regBe[1]) curAddr_reg[15:8] <= regWdata[15:8];
         end
      end
   end

   // ----------------------------------------
   // fetch engine
   // ----------------------------------------
   // a fetch waits a fixed count, then hands its word on in one pulse
   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         state_reg <= ST_IDLE;
         waitCnt_reg <= 3'h0;
         memReq <= 1'b0;
         memAddr <= 16'h0000;
         crcDataValid <= 1'b0;
         crcData <= 16'h0000;
      end
      else if (clkEn)
      begin
         crcDataValid <= 1'b0;
         memReq <= 1'b0;
         case (state_reg)
            ST_IDLE:
            begin
               if (fetchStart)
               begin
                  state_reg <= ST_FETCH;
                  memReq <= 1'b1;
                  memAddr <= curAddr_reg;
                  waitCnt_reg <= FETCH_CYC - 3'h1;
               end
            end
            ST_FETCH:
            begin
               if (fetchDone)
               begin
                  state_reg <= ST_IDLE;
                  crcData <= memRdata;
                  crcDataValid <= 1'b1;
               end
               else
                  waitCnt_reg <= waitCnt_reg - 3'h1;
            end
            default:
               state_reg <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // trigger event latch
   // ----------------------------------------
   // events are latched so a short pulse is not missed; one pending at most
   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         trigPrev_reg <= 1'b0;
         trigPend_reg <= 1'b0;
      end
      else if (clkEn)
      begin
         trigPrev_reg <= trigSrc;
         if (!isTrig || !go_reg)
            trigPend_reg <= 1'b0;
         else if (trigEdge)
            trigPend_reg <= 1'b1;
         else if (fetchStart)
            trigPend_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // interrupt status
   // ----------------------------------------
   // sticky events; a new event wins over a write-one clear
   always @(posedge clk)
   begin
      if (!rst_b)
         irqStat_reg <= 2'h0;
      else if (clkEn)
      begin
         if (wSta)
            irqStat_reg <= irqStat_reg & ~regWdata[1:0];
         if (hwClrGo && pastEnd)
            irqStat_reg[`NVMSC_IRQ_DONE] <= 1'b1;
         if (go_reg && en_reg && abortFlag)
            irqStat_reg[`NVMSC_IRQ_ABORT] <= 1'b1;
      end
   end

   // ----------------------------------------
   // read data, one cycle after the strobe
   // ----------------------------------------
   always @(posedge clk)
   begin
      if (!rst_b)
         regRdata <= 32'h0000_0000;
      else if (clkEn)
      begin
         regRdata <= 32'h0000_0000; // unmapped reads return zero
         if (regRd)
         begin
            case (wIdx)
               `NVMSC_IDX_END_ADDR: regRdata <= {16'h0000, endAddr_reg};
               `NVMSC_IDX_CUR_ADDR: regRdata <= {16'h0000, curAddr_reg};
               `NVMSC_IDX_CONTROL: regRdata <= {24'h000000, en_reg, go_reg, busy,
                  abortFlag, irqMode_reg, 1'b0, mode_reg};
               `NVMSC_IDX_TRIG_SEL: regRdata <= {28'h0000000, trigSel_reg};
               `NVMSC_IDX_TAP_MASK: regRdata <= tapMask_reg;
               `NVMSC_IDX_IRQ_STAT: regRdata <= {30'h0, irqStat_reg};
               `NVMSC_IDX_IRQ_MASK: regRdata <= {30'h0, irqMask_reg};
               `NVMSC_IDX_CRC_CTRL: regRdata <= {30'h0, crc_go_bit_reg, crc_enable_bit_reg};
               default: regRdata <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule

/* File: verification/nvmsc_mem_model.sv */
// memory model: answers each scanner fetch with a word derived from its address
// assumes one fetch in flight and a two-cycle fetch time
`timescale 1ns/1ps
module nvmsc_mem_model
(
   input wire clk,
   input wire memReq,
   input wire [15:0] memAddr,
   output logic [15:0] memRdata
);
   logic [15:0] word = 16'h0;
   logic live = 1'b0;
   // word stands one cycle, then turns to its inverse so stale sampling shows
   always @(posedge clk)
   begin
      live <= memReq;
      if (memReq)
         word <= memAddr ^ 16'hc3a5;
   end
   assign memRdata = live ? word : ~word;
endmodule

/* File: verification/nvmsc_scanner_assertions.sv */
// port checks of the nvm scanner
// assumes clkEn drops only while the scanner is idle and read data are zero
`timescale 1ns/1ps
`include "nvmsc_map.vh"
module nvmsc_scanner_assertions
(
   input wire clk,
   input wire rst_b,
   input wire regRd,
   input wire regWr,
   input wire [31:0] regRdata,
   input wire memReq,
   input wire [15:0] memAddr,
   input wire [15:0] memRdata,
   input wire crcDataValid,
   input wire [15:0] crcData,
   input wire [31:0] crcTapMask,
   input wire crcEnable,
   input wire crc_go_bit,
   input wire cpuIrqStall,
   input wire irq
);
   // ------------------------------
   // properties
   // ------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_rdIdle; !regRd |=> regRdata == 32'h0; endproperty
   property p_resetVals; $rose(rst_b) |-> crcTapMask == 32'h0 && !memReq; endproperty
   property p_tapHold; !regWr |=> $stable(crcTapMask); endproperty
   property p_crcTime; memReq |=> !crcDataValid ##1 crcDataValid; endproperty
   property p_wordPass; crcDataValid |-> crcData == $past(memRdata); endproperty
   property p_reqSpace; memReq |=> !memReq [*2]; endproperty
   property p_addrStep; memReq ##3 memReq |-> memAddr == $past(memAddr, 3) + 16'h1; endproperty
   property p_crcReady; memReq |-> $past(crc_go_bit && crcEnable); endproperty
   property p_validMem; memReq |-> memAddr <= `NVMSC_MEM_LAST; endproperty
   a_rdIdle: assert property (p_rdIdle) else $error("read data left standing");
   a_resetVals: assert property (p_resetVals) else $error("bad value after reset");
   a_tapHold: assert property (p_tapHold) else $error("tap mask moved without write");
   a_crcTime: assert property (p_crcTime) else $error("crc word not two after fetch");
   a_wordPass: assert property (p_wordPass) else $error("crc word not memory word");
   a_reqSpace: assert property (p_reqSpace) else $error("fetches too close");
   a_addrStep: assert property (p_addrStep) else $error("fetch address not stepped");
   a_crcReady: assert property (p_crcReady) else $error("fetch with crc stopped");
   a_validMem: assert property (p_validMem) else $error("fetch outside memory");
   c_fetch: cover property (memReq ##3 memReq);
   c_stall: cover property (cpuIrqStall);
   c_irq: cover property (irq);
endmodule

/* File: verification/nvmsc_testbench.sv */
// self-checking bench of the nvm scanner: register tasks and scan sequences
// assumes the memory model on the fetch side; clkEn dropped once while idle
`timescale 1ns/1ps
`include "nvmsc_map.vh"
module testbench;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic clkEn = 1'b1;
   logic [17:0] regAddr = 18'h0;
   logic [31:0] regWdata = 32'h0;
   logic [3:0] regBe = 4'h0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic cpuIrqActive = 1'b0;
   logic [10:0] trig = 11'h0;
   logic [31:0] regRdata, crcTapMask, rdv;
   logic [15:0] memAddr, memRdata, crcData;
   logic [15:0] expAddr = 16'h0;
   logic irq, cpuIrqStall, memReq, crcDataValid, crcEnable, crc_go_bit;
   logic busySeen = 1'b0;
   logic stallSeen = 1'b0;
   int badCount = 0;
   int cmpCount = 0;
   int words = 0;
   nvmsc_scanner nvmsc_scanner_inst
   (
      .clk, .rst_b, .clkEn(clkEn), .regAddr, .regWdata, .regBe, .regWr, .regRd, .regRdata,
      .irq, .cpuIrqActive, .cpuIrqStall, .memReq, .memAddr, .memRdata, .crcDataValid,
      .crcData, .crcTapMask, .crcEnable, .crc_go_bit, .lowFreqInternalOsc(trig[0]),
      .refClockOut(trig[1]), .timer0Overflow(trig[2]), .timer1Overflow(trig[3]),
      .timer2Postscaled(trig[4]), .timer3Overflow(trig[5]), .timer4Postscaled(trig[6]),
      .logicCell1Out(trig[7]), .logicCell2Out(trig[8]), .logicCell3Out(trig[9]),
      .logicCell4Out(trig[10])
   );
   nvmsc_mem_model nvmsc_mem_model_inst (.clk, .memReq, .memAddr, .memRdata);
   // ------------------------------
   // tasks
   // ------------------------------
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmpCount++;
      if (seen !== exp)
      begin
         badCount++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [3:0] be);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= {idx, 2'b00};
      regWdata <= d;
      regBe <= be;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] idx);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= {idx, 2'b00};
      @(posedge clk);
      regRd <= 1'b0;
      #1 rdv = regRdata;
   endtask
   // polls go; reads come every two cycles, so a two-cycle fetch shows busy
   task automatic waitIdle();
      for (int i = 0; i < 60; i++)
      begin
         rd(`NVMSC_IDX_CONTROL);
         busySeen = busySeen | rdv[`NVMSC_CTL_BUSY];
         if (rdv[`NVMSC_CTL_GO] === 1'b0)
            return;
      end
      chk("scan end", 32'h1, 32'h0);
   endtask
   task automatic scan(input logic [7:0] ctl, input logic [15:0] first, input logic [15:0] last);
      wr(`NVMSC_IDX_CUR_ADDR, {16'h0, first}, 4'h3);
      wr(`NVMSC_IDX_END_ADDR, {16'h0, last}, 4'h3);
      expAddr = first;
      words = 0;
      wr(`NVMSC_IDX_CONTROL, {24'h0, ctl}, 4'h1);
   endtask
   task automatic tallyAndFinish();
      $display("comparisons %0d mismatches %0d", cmpCount, badCount);
      if (badCount == 0 && cmpCount > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ------------------------------
   // clock, monitor, watchdog, tests
   // ------------------------------
   initial
   begin
      forever #5 clk = ~clk;
   end
   // every word handed to the crc engine is checked against its address
   always @(posedge clk)
   begin
      if (crcDataValid === 1'b1)
      begin
         chk("crc word", {16'h0, crcData}, {16'h0, expAddr ^ 16'hc3a5});
         expAddr = expAddr + 16'h1;
         words++;
      end
      stallSeen = stallSeen | (cpuIrqStall === 1'b1);
   end
   initial
   begin
      #300000;
      badCount++;
      tallyAndFinish();
   end
   initial
   begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      rd(`NVMSC_IDX_END_ADDR);
      chk("end addr", rdv & 32'hffff, 32'hffff);
      rd(`NVMSC_IDX_CUR_ADDR);
      chk("cur addr", rdv & 32'hffff, 32'h0);
      rd(`NVMSC_IDX_CONTROL);
      chk("control", rdv & 32'hff, 32'h10);
      rd(`NVMSC_IDX_TRIG_SEL);
      chk("trig sel", rdv & 32'hf, 32'h0);
      rd(`NVMSC_IDX_TAP_MASK);
      chk("tap reset", rdv, 32'h0);
      // a write while the clock enable is low must leave no trace
      clkEn <= 1'b0;
      wr(`NVMSC_IDX_TRIG_SEL, 32'h5, 4'h1);
      clkEn <= 1'b1;
      rd(`NVMSC_IDX_TRIG_SEL);
      chk("frozen", rdv & 32'hf, 32'h0);
      wr(`NVMSC_IDX_TAP_MASK, 32'h11223344, 4'hf);
      wr(`NVMSC_IDX_TAP_MASK, 32'haabbccdd, 4'h5);
      rd(`NVMSC_IDX_TAP_MASK);
      chk("tap lanes", rdv, 32'h11bb33dd);
      chk("tap out", crcTapMask, 32'h11bb33dd);
      rd(16'h1c93);
      chk("unmapped", rdv, 32'h0);
      wr(`NVMSC_IDX_CRC_CTRL, 32'h3, 4'h1);
      #1 chk("crc out", {30'h0, crc_go_bit, crcEnable}, 32'h3);
      wr(`NVMSC_IDX_CUR_ADDR, 32'h8000, 4'h3);
      rd(`NVMSC_IDX_CONTROL);
      chk("abort high", rdv & 32'h10, 32'h10);
      $display("test registers done");
      wr(`NVMSC_IDX_IRQ_MASK, 32'h1, 4'h1);
      scan(8'hc0, 16'h0010, 16'h0012);
      wr(`NVMSC_IDX_END_ADDR, 32'h0100, 4'h3);
      waitIdle();
      chk("words", 32'(words), 32'h3);
      chk("busy seen", {31'h0, busySeen}, 32'h1);
      chk("stall seen", {31'h0, stallSeen}, 32'h1);
      rd(`NVMSC_IDX_CUR_ADDR);
      chk("cur after", rdv & 32'hffff, 32'h13);
      rd(`NVMSC_IDX_END_ADDR);
      chk("end kept", rdv & 32'hffff, 32'h12);
      rd(`NVMSC_IDX_CONTROL);
      chk("idle ctl", rdv & 32'hf0, 32'h80);
      chk("irq set", {31'h0, irq}, 32'h1);
      wr(`NVMSC_IDX_IRQ_STAT, 32'h1, 4'h1);
      #1 chk("irq clear", {31'h0, irq}, 32'h0);
      // go set with the scanner disabled: nothing moves until enable
      scan(8'h40, 16'h0050, 16'h0050);
      repeat (10) @(posedge clk);
      chk("disabled", 32'(words), 32'h0);
      rd(`NVMSC_IDX_TAP_MASK);
      chk("tap kept", rdv, 32'h11bb33dd);
      wr(`NVMSC_IDX_CONTROL, 32'hc0, 4'h1);
      waitIdle();
      chk("enabled", 32'(words), 32'h1);
      $display("test concurrent done");
      scan(8'hc1, 16'h0020, 16'h0021);
      repeat (4) @(posedge clk);
      #1 chk("burst stall", {31'h0, cpuIrqStall}, 32'h1);
      waitIdle();
      #1 chk("burst free", {31'h0, cpuIrqStall}, 32'h0);
      chk("burst words", 32'(words), 32'h2);
      $display("test burst done");
      foreach (rdv[i])
      begin
         if (i < 3)
         begin
            cpuIrqActive <= 1'b1;
            scan(i == 0 ? 8'hc8 : (i == 1 ? 8'hc2 : 8'hc9), 16'h0030, 16'h0031);
            repeat (20) @(posedge clk);
            chk("paused", 32'(words), 32'h0);
            cpuIrqActive <= 1'b0;
            waitIdle();
            chk("resumed", 32'(words), 32'h2);
         end
      end
      $display("test pause done");
      for (int c = 0; c < 13; c++)
      begin
         wr(`NVMSC_IDX_TRIG_SEL, 32'(c), 4'h1);
         scan(8'hc3, 16'h0040, 16'h0040);
         trig <= (c == 7 || c == 12) ? 11'h7ff : ~(11'h1 << (c < 7 ? c : c - 1));
         repeat (2) @(posedge clk);
         trig <= 11'h0;
         repeat (8) @(posedge clk);
         chk("no event", 32'(words), 32'h0);
         if (c == 7 || c == 12)
         begin
            wr(`NVMSC_IDX_CRC_CTRL, 32'h1, 4'h1);
            repeat (3) @(posedge clk);
            rd(`NVMSC_IDX_CONTROL);
            chk("go dropped", rdv & 32'h40, 32'h0);
            chk("crc go low", {31'h0, crc_go_bit}, 32'h0);
            wr(`NVMSC_IDX_CRC_CTRL, 32'h3, 4'h1);
         end
         else
         begin
            trig <= 11'h1 << (c < 7 ? c : c - 1);
            @(posedge clk);
            trig <= 11'h0;
            repeat (8) @(posedge clk);
            chk("one fetch", 32'(words), 32'h1);
            waitIdle();
         end
      end
      $display("test trigger done");
      tallyAndFinish();
   end
endmodule
bind nvmsc_scanner nvmsc_scanner_assertions nvmsc_scanner_assertions_inst
(
   .clk, .rst_b, .regRd, .regWr, .regRdata, .memReq, .memAddr, .memRdata, .crcDataValid,
   .crcData, .crcTapMask, .crcEnable, .crc_go_bit, .cpuIrqStall, .irq
);
